// ==== src/dual_timer_regs.svh ====
// timer block constants: field positions, reset values, timing counts
// assumes inclusion by the timer modules (per_cycle_div and dual_timer)
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH
`define CLK_PERIOD_NS 10
`define PER_CYCLE_CLKS 6
`define MODE_GATE_BIT 3
`define MODE_SRC_BIT 2
`define MODE_HI_BIT 1
`define MODE_LO_BIT 0
`define CH1_MODE_SHIFT 4
`define CTRL_OVF1_BIT 7
`define CTRL_RUN1_BIT 6
`define CTRL_OVF0_BIT 5
`define CTRL_RUN0_BIT 4
`define CTRL_EDGE1_BIT 3
`define CTRL_TYPE1_BIT 2
`define CTRL_EDGE0_BIT 1
`define CTRL_TYPE0_BIT 0
`define MODE_RESET 8'h00
`define CTRL_RESET 8'h00
`define COUNT_RESET 8'h00
`define PRESCALE_MASK 8'h1f
`endif

// ==== src/dual_timer_pkg.sv ====
// types used by the dual_timer module
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } timer_mode_type;
endpackage

// ==== src/pin_sync.sv ====
// two-flop synchroniser for one level input
// assumes a single clock domain
`timescale 1ns/1ns
module pin_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // level in and out
    input wire logic i_d,
    output logic o_q
);
    logic meta_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule

// ==== src/per_cycle_div.sv ====
// peripheral cycle enable: one pulse every DIV clocks
// assumes one clock, async active-high reset
`timescale 1ns/1ns
`include "dual_timer_regs.svh"
module per_cycle_div #(
    parameter int DIV = `PER_CYCLE_CLKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // enable pulse
    output logic o_tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    logic [W-1:0] cnt_ff;
    initial begin
        if (DIV < 2) $error("per_cycle_div: DIV must be at least 2");
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else if (cnt_ff == W'(DIV - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    assign o_tick = (cnt_ff == W'(DIV - 1));
endmodule

// ==== src/dual_timer.sv ====
// two 8+8 bit timer/counter channels with modes 0..3, overflow flags and irqs
// assumes core writes registers through plain strobes; pins are asynchronous
`timescale 1ns/1ns
`include "dual_timer_regs.svh"
// Function
// R1 - low and high bytes chain into 16 bits; high carry sets overflow
// R2 - run bit set lets the chosen source increment the low byte
// R3 - setting run leaves count bytes unchanged
// R4 - software reads any time; presets only while stopped
// R5 - software stops a channel before changing source or mode
// R6 - timer source counts once per six clock peripheral cycle
// R7 - counter source counts a high sample followed by a low sample
// R8 - external count levels are held at least one peripheral cycle
// R9 - gate clear: run alone enables; gate set: irq pin also gates
// R10 - gated channel counts only while irq pin high and run set
// R11 - rollover from all ones to zero sets overflow flag
// R12 - channel 0 uses mode bits 3:0 and control bits 0,1,4,5
// R13 - channel 1 uses mode bits 7:4 and control bits 2,3,6,7
// R14 - mode 0: high byte counts, five bit prescaler in low byte
// R15 - mode 1: full sixteen bit counter
// R16 - mode 2: low byte counts, reloads from high byte on overflow
// R17 - mode 2 reload value may be rewritten any time
// R18 - channel 0 mode 3: low byte is eight bit counter, own controls
// R19 - channel 0 mode 3: high byte times, run1 starts it, sets overflow1
// R20 - channel 1 mode 3 halts and keeps its count
// R21 - mode bits 00,01,10,11 select modes 0,1,2,3
// R22 - vectoring to a channel's interrupt clears its overflow flag
// R23 - overflow irq needs per-timer and global enables
// R24 - counts, mode and control registers reset to zero
// R25 - hardware set beats simultaneous clear of an overflow flag
// R26 - count and gate pins pass a two-stage synchroniser
module dual_timer
    import dual_timer_pkg::*;
#(
    parameter int PER_DIV = `PER_CYCLE_CLKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // external pins
    input wire logic i_count_pin0,
    input wire logic i_count_pin1,
    input wire logic i_ext_irq_pin_zero,
    input wire logic i_ext_irq_pin_one,
    // mode register write
    input wire logic i_mode_we,
    input wire logic [7:0] i_mode_wdata,
    // control register write (run, type bits and software flag writes)
    input wire logic i_ctrl_we,
    input wire logic [7:0] i_ctrl_wdata,
    // count byte writes
    input wire logic i_low_byte_ch0_we,
    input wire logic i_high_byte_ch0_we,
    input wire logic i_low_byte_ch1_we,
    input wire logic i_high_byte_ch1_we,
    input wire logic [7:0] i_byte_wdata,
    // interrupt enables and vector acknowledges
    input wire logic i_per_timer_irq_enable0,
    input wire logic i_per_timer_irq_enable1,
    input wire logic i_global_irq_enable,
    input wire logic i_vector_ack0,
    input wire logic i_vector_ack1,
    // register contents
    output logic [7:0] o_timer_mode_reg,
    output logic [7:0] o_timer_control_reg,
    output logic [7:0] o_low_byte_ch0,
    output logic [7:0] o_high_byte_ch0,
    output logic [7:0] o_low_byte_ch1,
    output logic [7:0] o_high_byte_ch1,
    // interrupt requests
    output logic o_irq_ch0,
    output logic o_irq_ch1
);
    logic [7:0] mode_ff;
    logic run0_ff, run1_ff, ovf0_ff, ovf1_ff;
    logic edge0_ff, edge1_ff, type0_ff, type1_ff;
    logic [7:0] lo0_ff, hi0_ff, lo1_ff, hi1_ff;
    logic cnt0_s, cnt1_s, gate_ch0_s, gate_ch1_s;
    logic samp0_ff, samp1_ff, prev0_ff, prev1_ff;
    logic gate_ch0_prev_ff, gate_ch1_prev_ff;
    logic tick;
    timer_mode_type mode0, mode1;
    logic src0, src1, gate_ch0, gate_ch1;
    logic fall0, fall1, inc0, inc1, inc0_hi;
    logic set_ovf0, set_ovf1;
    logic [8:0] lo0_sum, hi0_sum, lo1_sum, hi1_sum;
    logic [5:0] pre0_sum, pre1_sum;

    initial begin
        if (PER_DIV != `PER_CYCLE_CLKS) $error("dual_timer: PER_DIV must be 6");
    end

    // see R26
    pin_sync u_sync_cnt0 (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_count_pin0), .o_q(cnt0_s));
    pin_sync u_sync_cnt1 (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_count_pin1), .o_q(cnt1_s));
    pin_sync u_sync_gt0 (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_ext_irq_pin_zero), .o_q(gate_ch0_s));
    pin_sync u_sync_gt1 (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_ext_irq_pin_one), .o_q(gate_ch1_s));

    // see R6
    per_cycle_div #(.DIV(PER_DIV)) u_div (.i_clk(i_clk), .i_rst(i_rst), .o_tick(tick));

    // see R12 see R13 see R21
    assign mode0 = timer_mode_type'(mode_ff[`MODE_HI_BIT:`MODE_LO_BIT]);
    assign mode1 = timer_mode_type'(mode_ff[`CH1_MODE_SHIFT+`MODE_HI_BIT:`CH1_MODE_SHIFT]);
    assign src0 = mode_ff[`MODE_SRC_BIT];
    assign src1 = mode_ff[`CH1_MODE_SHIFT+`MODE_SRC_BIT];
    assign gate_ch0 = mode_ff[`MODE_GATE_BIT];
    assign gate_ch1 = mode_ff[`CH1_MODE_SHIFT+`MODE_GATE_BIT];

    // count pin sampled once per peripheral cycle; see R7
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            samp0_ff <= 1'b0;
            samp1_ff <= 1'b0;
            prev0_ff <= 1'b0;
            prev1_ff <= 1'b0;
        end else if (tick) begin
            samp0_ff <= cnt0_s;
            samp1_ff <= cnt1_s;
            prev0_ff <= samp0_ff;
            prev1_ff <= samp1_ff;
        end
    end
    assign fall0 = prev0_ff & ~samp0_ff;
    assign fall1 = prev1_ff & ~samp1_ff;

    // count enable: run, optional gating, then source; see R2 see R9 see R10
    assign inc0 = tick & run0_ff & (~gate_ch0 | gate_ch0_s) & (src0 ? fall0 : 1'b1);
    assign inc1 = tick & run1_ff & (~gate_ch1 | gate_ch1_s) & (src1 ? fall1 : 1'b1)
                  & (mode1 != MODE_SPLIT) & (mode0 != MODE_SPLIT);
    // split mode high byte: fixed timer source under run1; see R19
    assign inc0_hi = tick & run1_ff & (mode0 == MODE_SPLIT);

    assign lo0_sum = {1'b0, lo0_ff} + 9'h001;
    assign hi0_sum = {1'b0, hi0_ff} + 9'h001;
    assign lo1_sum = {1'b0, lo1_ff} + 9'h001;
    assign hi1_sum = {1'b0, hi1_ff} + 9'h001;
    assign pre0_sum = {1'b0, lo0_ff[4:0]} + 6'h01;
    assign pre1_sum = {1'b0, lo1_ff[4:0]} + 6'h01;

    // overflow events; see R1 see R11
    always_comb begin
        set_ovf0 = 1'b0;
        set_ovf1 = 1'b0;
        if (inc0) begin
            case (mode0)
                MODE_13BIT: set_ovf0 = pre0_sum[5] & hi0_sum[8];
                MODE_16BIT: set_ovf0 = lo0_sum[8] & hi0_sum[8];
                MODE_RELOAD: set_ovf0 = lo0_sum[8];
                MODE_SPLIT: set_ovf0 = lo0_sum[8];
                default: set_ovf0 = 1'b0;
            endcase
        end
        if (inc1) begin
            case (mode1)
                MODE_13BIT: set_ovf1 = pre1_sum[5] & hi1_sum[8];
                MODE_16BIT: set_ovf1 = lo1_sum[8] & hi1_sum[8];
                MODE_RELOAD: set_ovf1 = lo1_sum[8];
                default: set_ovf1 = 1'b0;
            endcase
        end
        if (inc0_hi & hi0_sum[8]) begin
            set_ovf1 = 1'b1;
        end
    end

    // channel 0 count bytes; write wins as software only writes when stopped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo0_ff <= `COUNT_RESET; // see R24
        end else if (i_low_byte_ch0_we) begin
            lo0_ff <= i_byte_wdata; // see R4
        end else if (inc0) begin
            case (mode0)
                // upper three bits kept as written, only prescaler counts; see R14
                MODE_13BIT: lo0_ff <= {lo0_ff[7:5], pre0_sum[4:0]};
                MODE_RELOAD: lo0_ff <= lo0_sum[8] ? hi0_ff : lo0_sum[7:0]; // see R16
                default: lo0_ff <= lo0_sum[7:0]; // see R15 see R18
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hi0_ff <= `COUNT_RESET;
        end else if (i_high_byte_ch0_we) begin
            hi0_ff <= i_byte_wdata; // see R17
        end else if (mode0 == MODE_SPLIT) begin
            if (inc0_hi) hi0_ff <= hi0_sum[7:0]; // see R19
        end else if (inc0) begin
            case (mode0)
                MODE_13BIT: if (pre0_sum[5]) hi0_ff <= hi0_sum[7:0]; // see R14
                MODE_16BIT: if (lo0_sum[8]) hi0_ff <= hi0_sum[7:0]; // see R1
                default: hi0_ff <= hi0_ff; // reload leaves it; see R16
            endcase
        end
    end

    // channel 1 count bytes; mode 3 simply never increments; see R20
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo1_ff <= `COUNT_RESET;
        end else if (i_low_byte_ch1_we) begin
            lo1_ff <= i_byte_wdata;
        end else if (inc1) begin
            case (mode1)
                MODE_13BIT: lo1_ff <= {lo1_ff[7:5], pre1_sum[4:0]};
                MODE_RELOAD: lo1_ff <= lo1_sum[8] ? hi1_ff : lo1_sum[7:0];
                default: lo1_ff <= lo1_sum[7:0];
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hi1_ff <= `COUNT_RESET;
        end else if (i_high_byte_ch1_we) begin
            hi1_ff <= i_byte_wdata;
        end else if (inc1) begin
            case (mode1)
                MODE_13BIT: if (pre1_sum[5]) hi1_ff <= hi1_sum[7:0];
                MODE_16BIT: if (lo1_sum[8]) hi1_ff <= hi1_sum[7:0];
                default: hi1_ff <= hi1_ff;
            endcase
        end
    end

    // mode register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= `MODE_RESET;
        end else if (i_mode_we) begin
            mode_ff <= i_mode_wdata; // see R5
        end
    end

    // run and type bits; writing run does not touch counts; see R3
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run0_ff <= 1'b0;
            run1_ff <= 1'b0;
            type0_ff <= 1'b0;
            type1_ff <= 1'b0;
        end else if (i_ctrl_we) begin
            run0_ff <= i_ctrl_wdata[`CTRL_RUN0_BIT];
            run1_ff <= i_ctrl_wdata[`CTRL_RUN1_BIT];
            type0_ff <= i_ctrl_wdata[`CTRL_TYPE0_BIT];
            type1_ff <= i_ctrl_wdata[`CTRL_TYPE1_BIT];
        end
    end

    // overflow flags: set beats clear; see R25 see R22
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovf0_ff <= 1'b0;
            ovf1_ff <= 1'b0;
        end else begin
            if (set_ovf0) ovf0_ff <= 1'b1;
            else if (i_vector_ack0) ovf0_ff <= 1'b0;
            else if (i_ctrl_we) ovf0_ff <= i_ctrl_wdata[`CTRL_OVF0_BIT];
            if (set_ovf1) ovf1_ff <= 1'b1;
            else if (i_vector_ack1) ovf1_ff <= 1'b0;
            else if (i_ctrl_we) ovf1_ff <= i_ctrl_wdata[`CTRL_OVF1_BIT];
        end
    end

    // edge flags of the external irq pins, shown in control reg; core clears by write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_ch0_prev_ff <= 1'b0;
            gate_ch1_prev_ff <= 1'b0;
            edge0_ff <= 1'b0;
            edge1_ff <= 1'b0;
        end else begin
            gate_ch0_prev_ff <= gate_ch0_s;
            gate_ch1_prev_ff <= gate_ch1_s;
            if (type0_ff & gate_ch0_prev_ff & ~gate_ch0_s) edge0_ff <= 1'b1;
            else if (i_ctrl_we) edge0_ff <= i_ctrl_wdata[`CTRL_EDGE0_BIT];
            if (type1_ff & gate_ch1_prev_ff & ~gate_ch1_s) edge1_ff <= 1'b1;
            else if (i_ctrl_we) edge1_ff <= i_ctrl_wdata[`CTRL_EDGE1_BIT];
        end
    end

    assign o_timer_mode_reg = mode_ff;
    assign o_timer_control_reg = {ovf1_ff, run1_ff, ovf0_ff, run0_ff,
                                  edge1_ff, type1_ff, edge0_ff, type0_ff};
    assign o_low_byte_ch0 = lo0_ff;
    assign o_high_byte_ch0 = hi0_ff;
    assign o_low_byte_ch1 = lo1_ff;
    assign o_high_byte_ch1 = hi1_ff;
    // see R23
    assign o_irq_ch0 = ovf0_ff & i_per_timer_irq_enable0 & i_global_irq_enable;
    assign o_irq_ch1 = ovf1_ff & i_per_timer_irq_enable1 & i_global_irq_enable;

    a_split_hi_ovf: assert property (@(posedge i_clk) disable iff (i_rst) // see R19
        inc0_hi && hi0_ff == 8'hff |=> ovf1_ff && hi0_ff == 8'h00)
        else $error("split high byte overflow missed");
    a_reload_val: assert property (@(posedge i_clk) disable iff (i_rst) // see R16
        inc0 && mode0 == MODE_RELOAD && lo0_ff == 8'hff && !i_low_byte_ch0_we
        && !i_high_byte_ch0_we |=> lo0_ff == $past(hi0_ff) && ovf0_ff)
        else $error("reload did not load high byte");
    a_m16_carry: assert property (@(posedge i_clk) disable iff (i_rst) // see R1
        inc0 && mode0 == MODE_16BIT && lo0_ff == 8'hff && !i_high_byte_ch0_we
        && !i_low_byte_ch0_we |=> hi0_ff == $past(hi0_ff) + 8'h01)
        else $error("low byte carry lost");
    a_m0_prescale: assert property (@(posedge i_clk) disable iff (i_rst) // see R14
        inc0 && mode0 == MODE_13BIT && lo0_ff[4:0] != 5'h1f && !i_high_byte_ch0_we
        && !i_low_byte_ch0_we |=> $stable(hi0_ff))
        else $error("prescaler carried early");
    a_stop_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
        !run0_ff && !i_low_byte_ch0_we |=> $stable(lo0_ff))
        else $error("stopped channel counted");
    a_ch1_halt: assert property (@(posedge i_clk) disable iff (i_rst) // see R20
        mode1 == MODE_SPLIT && !i_low_byte_ch1_we |=> $stable(lo1_ff))
        else $error("halted channel 1 counted");
    a_gate_block: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
        gate_ch0 && !gate_ch0_s |-> !inc0)
        else $error("gated channel counted with pin low");
    a_set_wins: assert property (@(posedge i_clk) disable iff (i_rst) // see R25
        set_ovf0 && i_vector_ack0 |=> ovf0_ff)
        else $error("overflow lost to clear");
    a_tick_rate: assert property (@(posedge i_clk) disable iff (i_rst) // see R6
        tick |=> !tick [*5] ##1 tick)
        else $error("peripheral cycle not six clocks");
    a_irq_gate: assert property (@(posedge i_clk) disable iff (i_rst) // see R23
        o_irq_ch1 |-> ovf1_ff && i_per_timer_irq_enable1 && i_global_irq_enable)
        else $error("irq without enables");
    c_ovf0: cover property (@(posedge i_clk) set_ovf0);
    c_split: cover property (@(posedge i_clk) inc0_hi && hi0_ff == 8'hff);
    c_ext_count: cover property (@(posedge i_clk) inc1 && src1);
    // edge flag shares the synchronised gate pin, so its delay matches gating
    a_edge_set: assert property (@(posedge i_clk) disable iff (i_rst) // see R12
        type0_ff && gate_ch0_prev_ff && !gate_ch0_s |=> edge0_ff)
        else $error("pin edge flag not set");
    a_run1_taken: assert property (@(posedge i_clk) disable iff (i_rst) // see R19
        mode0 == MODE_SPLIT |-> !inc1)
        else $error("channel 1 counted while its run bit was taken");
    c_rld1: cover property (@(posedge i_clk) inc1 && mode1 == MODE_RELOAD && lo1_ff == 8'hff);
    c_edge0: cover property (@(posedge i_clk) type0_ff && gate_ch0_prev_ff && !gate_ch0_s);
endmodule

// ==== dv/pin_source.sv ====
// stand-in for the outside world driving one external count pin
// assumes the bench calls pulses() just after a rising clock edge
`timescale 1ns/1ns
module pin_source (
    // clock
    input wire logic i_clk,
    // count pin
    output logic o_pin
);
    initial o_pin = 1'b0;

    // each level held for whole clocks, never under one peripheral cycle
    task automatic pulses(input int n, input int hold);
        int h;
        h = (hold < 6) ? 6 : hold;
        repeat (n) begin
            o_pin = 1'b1;
            repeat (h) @(posedge i_clk);
            #1 o_pin = 1'b0;
            repeat (h) @(posedge i_clk);
            #1;
        end
    endtask
endmodule

// ==== dv/tb_dual_timer.sv ====
// self-checking bench for the dual timer: presets, modes, gating, pin counting, irqs
// assumes a 100 MHz clock and a peripheral cycle of six clocks
`timescale 1ns/1ns
module tb_dual_timer;
    localparam int M = 0, C = 1, L0 = 2, H0 = 3, L1 = 4, H1 = 5;
    logic clk = 1'b0, rst = 1'b1, pin0 = 1'b0, gate_ch0 = 1'b0, gate_ch1 = 1'b0;
    logic mwe = 1'b0, cwe = 1'b0, en0 = 1'b0, en1 = 1'b0, gen = 1'b0;
    logic ack0 = 1'b0, ack1 = 1'b0;
    logic we_l0 = 1'b0, we_h0 = 1'b0, we_l1 = 1'b0, we_h1 = 1'b0;
    logic [7:0] mdat = 8'h00, cdat = 8'h00, bdat = 8'h00;
    logic [7:0] mode_q, ctrl_q, lo0, hi0, lo1, hi1;
    logic irq0, irq1;
    wire pin1;
    int n_mismatch = 0;
    int checks = 0;

    always #5 clk = ~clk;

    pin_source src (.i_clk(clk), .o_pin(pin1));

    dual_timer dut (
        .i_clk(clk), .i_rst(rst), .i_count_pin0(pin0), .i_count_pin1(pin1),
        .i_ext_irq_pin_zero(gate_ch0), .i_ext_irq_pin_one(gate_ch1),
        .i_mode_we(mwe), .i_mode_wdata(mdat), .i_ctrl_we(cwe), .i_ctrl_wdata(cdat),
        .i_low_byte_ch0_we(we_l0), .i_high_byte_ch0_we(we_h0),
        .i_low_byte_ch1_we(we_l1), .i_high_byte_ch1_we(we_h1), .i_byte_wdata(bdat),
        .i_per_timer_irq_enable0(en0), .i_per_timer_irq_enable1(en1),
        .i_global_irq_enable(gen), .i_vector_ack0(ack0), .i_vector_ack1(ack1),
        .o_timer_mode_reg(mode_q), .o_timer_control_reg(ctrl_q),
        .o_low_byte_ch0(lo0), .o_high_byte_ch0(hi0), .o_low_byte_ch1(lo1),
        .o_high_byte_ch1(hi1), .o_irq_ch0(irq0), .o_irq_ch1(irq1)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // only the selected strobe moves, so back-to-back writes never touch one strobe twice
    task automatic strobe(input int sel, input logic lvl);
        case (sel)
            M: mwe = lvl;
            C: cwe = lvl;
            L0: we_l0 = lvl;
            H0: we_h0 = lvl;
            L1: we_l1 = lvl;
            default: we_h1 = lvl;
        endcase
    endtask

    // one strobe for one cycle; sel picks mode, control or a count byte
    task automatic wr(input int sel, input logic [7:0] v);
        mdat = v;
        cdat = v;
        bdat = v;
        strobe(sel, 1'b1);
        step(1);
        strobe(sel, 1'b0);
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // phase of the divider is not pinned, so rates are checked within a window
    task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [7:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask

    task automatic wait_bit(input int b, input int bound);
        int k;
        for (k = 0; k < bound && ctrl_q[b] !== 1'b1; k++) step(1);
        if (k == bound) begin
            n_mismatch++;
            $display("CHECK FAILED control bit %0d expected 1 seen %b", b, ctrl_q[b]);
            report_and_stop();
        end
    endtask

    initial begin
        int v, n, h;
        void'($urandom(97));
        step(4);
        rst = 1'b0;
        chk("mode reg", 8'h00, mode_q);
        chk("ctrl reg", 8'h00, ctrl_q);
        chk("counts ch0", 8'h00, lo0 | hi0);
        chk("counts ch1", 8'h00, lo1 | hi1);
        wr(M, 8'h01);
        repeat (3) begin
            v = $urandom_range(8'he0, 0);
            h = $urandom_range(8'hff, 0);
            wr(L0, v[7:0]);
            wr(H0, h[7:0]);
            wr(C, 8'h10);
            chk_rng("lo0 at start", v[7:0], v[7:0] + 8'h01, lo0);
            chk("hi0 at start", h[7:0], hi0);
            step(59);
            wr(C, 8'h00);
            chk_rng("lo0 after 60", v[7:0] + 8'h09, v[7:0] + 8'h0b, lo0);
        end
        // vector ack held through the rollover must not hide the flag
        wr(L0, 8'hff);
        wr(H0, 8'hff);
        ack0 = 1'b1;
        wr(C, 8'h10);
        wait_bit(5, 14);
        chk("lo0 rolled", 8'h00, lo0);
        chk("hi0 rolled", 8'h00, hi0);
        ack0 = 1'b0;
        wr(C, 8'h20);
        for (n = 0; n < 4; n++) begin
            en0 = n[0];
            gen = n[1];
            step(1);
            chk("irq0", {7'h00, n[0] & n[1]}, {7'h00, irq0});
        end
        ack0 = 1'b1;
        step(1);
        ack0 = 1'b0;
        chk("ovf0 after ack", 8'h00, {7'h00, ctrl_q[5]});
        chk("irq0 after ack", 8'h00, {7'h00, irq0});
        wr(M, 8'h00);
        wr(L0, 8'h1f);
        wr(H0, 8'h10);
        wr(C, 8'h10);
        step(8);
        chk("hi0 prescaled", 8'h11, hi0);
        chk_rng("prescaler", 8'h00, 8'h01, lo0 & 8'h1f);
        wr(C, 8'h00);
        wr(L0, 8'h1f);
        wr(H0, 8'hff);
        wr(C, 8'h10);
        wait_bit(5, 14);
        chk("hi0 13 bit wrap", 8'h00, hi0);
        wr(C, 8'h00);
        wr(M, 8'h02);
        wr(H0, 8'ha0);
        wr(L0, 8'hfe);
        wr(C, 8'h10);
        wait_bit(5, 20);
        chk_rng("lo0 reload", 8'ha0, 8'ha1, lo0);
        chk("hi0 kept", 8'ha0, hi0);
        wr(H0, 8'hc0);
        wr(C, 8'h10);
        wait_bit(5, 700);
        chk_rng("lo0 new reload", 8'hc0, 8'hc1, lo0);
        wr(C, 8'h00);
        wr(M, 8'h09);
        wr(L0, 8'h00);
        wr(C, 8'h10);
        step(40);
        chk("lo0 gated off", 8'h00, lo0);
        gate_ch0 = 1'b1;
        step(59);
        wr(C, 8'h00);
        chk_rng("lo0 gated on", 8'h08, 8'h0a, lo0);
        // falling irq pin with type bit set raises the edge flag; a write clears it
        step(1);
        wr(C, 8'h01);
        gate_ch0 = 1'b0;
        step(4);
        chk("edge0 flag", 8'h03, ctrl_q & 8'h03);
        wr(C, 8'h00);
        chk("edge0 cleared", 8'h00, ctrl_q & 8'h03);
        // first pass is the shortest legal hold, then random pulse trains
        wr(M, 8'h50);
        for (n = 0; n < 4; n++) begin
            v = (n == 0) ? 1 : $urandom_range(10, 1);
            h = (n == 0) ? 6 : $urandom_range(15, 6);
            wr(L1, 8'h00);
            wr(C, 8'h40);
            src.pulses(v, h);
            step(20);
            wr(C, 8'h00);
            chk("lo1 edges", v[7:0], lo1);
        end
        wr(M, 8'h13);
        chk("mode reg split", 8'h13, mode_q);
        wr(L0, 8'h40);
        wr(H0, 8'hff);
        wr(L1, 8'h00);
        wr(C, 8'h40);
        wait_bit(7, 14);
        chk("lo0 idle", 8'h40, lo0);
        chk("hi0 wrapped", 8'h00, hi0);
        chk("lo1 idle", 8'h00, lo1);
        chk("ovf0 clear", 8'h00, {7'h00, ctrl_q[5]});
        wr(C, 8'h00);
        wr(L0, 8'hff);
        wr(C, 8'h10);
        wait_bit(5, 14);
        chk("lo0 split wrap", 8'h00, lo0);
        chk("hi0 held", 8'h00, hi0);
        wr(C, 8'h00);
        wr(M, 8'h30);
        wr(L1, 8'h33);
        wr(C, 8'h40);
        step(30);
        chk("lo1 halted", 8'h33, lo1);
        // channel 1 auto-reload with its interrupt enabled
        wr(C, 8'h00);
        wr(M, 8'h20);
        wr(H1, 8'h80);
        wr(L1, 8'hff);
        en1 = 1'b1;
        wr(C, 8'h40);
        wait_bit(7, 14);
        chk_rng("lo1 reload", 8'h80, 8'h81, lo1);
        chk("hi1 kept", 8'h80, hi1);
        chk("irq1", 8'h01, {7'h00, irq1});
        report_and_stop();
    end
endmodule
